// *** rtl/dmrz_decode.v ***
// Mode register zero decode, burst sequencing and write beat path
`timescale 1ns/100ps
`include "dmrz_map.vh"
module dmrz_decode (
   // Clock and reset
   input wire clock_i,
   input wire reset_i,
   // Command pins
   input wire ck_i,
   input wire cs_n_i,
   input wire ras_n_i,
   input wire cas_n_i,
   input wire we_n_i,
   input wire [2:0] ba_i,
   input wire [12:0] addr_i,
   // Data pins
   input wire [15:0] dq_i,
   output reg [15:0] dq_o,
   output reg dq_oe_o,
   output reg dqs_o,
   output reg dqs_oe_o,
   // Settings held by other mode registers and power logic
   input wire [3:0] added_latency_i,
   input wire [3:0] write_latency_i,
   input wire [4:0] precharge_period_i,
   input wire powerdown_i,
   // Written beats towards the array
   output reg [15:0] beat_data_o,
   output reg [2:0] beat_column_o,
   output reg beat_valid_o,
   input wire beat_ready_i,
   output reg write_path_ready_o,
   output reg beat_dropped_o,
   // Decoded mode state
   output reg [12:0] mode_reg_zero_o,
   output reg [4:0] column_latency_o,
   output reg [5:0] total_read_latency_o,
   output reg burst_interleave_o,
   output reg test_mode_o,
   output reg dll_reset_o,
   output reg dll_restart_o,
   output reg [4:0] write_recovery_o,
   output reg [5:0] autoprecharge_total_delay_o,
   output reg internal_write_start_o,
   output reg recovery_busy_o,
   output reg dll_frozen_o,
   output reg fast_exit_o
);
   // Column latency from A2 and A6..A4, whole cycles only
   function [4:0] cl_decode;
      input [12:0] mr;
      begin
         if (mr[`DMRZ_CL_LOW])
            cl_decode = `DMRZ_CL_HIGH + {2'h0, mr[`DMRZ_CL_HI:`DMRZ_CL_LO]}; // R1 R2
         else
            cl_decode = `DMRZ_CL_BASE + {2'h0, mr[`DMRZ_CL_HI:`DMRZ_CL_LO]}; // R1 R2
      end
   endfunction

   // Recovery cycles from A11..A9
   function [4:0] wr_decode;
      input [2:0] code;
      begin
         case (code)
            3'h0: wr_decode = `DMRZ_WR_ZERO;
            3'h1: wr_decode = 5'h05;
            3'h2: wr_decode = 5'h06;
            3'h3: wr_decode = 5'h07;
            3'h4: wr_decode = 5'h08;
            3'h5: wr_decode = 5'h0a;
            3'h6: wr_decode = 5'h0c;
            default: wr_decode = 5'h0e;
         endcase
      end
   endfunction

   // Column of beat number from the start column and burst type
   function [2:0] burst_col;
      input [2:0] start;
      input [2:0] beat;
      input interleave;
      reg [1:0] low;
      begin
         low = start[1:0] + beat[1:0];
         if (interleave)
            burst_col = start ^ beat; // R7
         else
            burst_col = {start[2] ^ beat[2], low}; // R7
      end
   endfunction

   // Settled pins
   wire [36:0] pins;
   wire ck_level;
   wire cs_n;
   wire ras_n;
   wire cas_n;
   wire we_n;
   wire [2:0] ba;
   wire [12:0] addr;
   wire [15:0] dq;
   dmrz_sync #(
      .WIDTH(37)
   ) u_sync (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .pin_i({ck_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i, dq_i}),
      .level_o(pins)
   );
   assign {ck_level, cs_n, ras_n, cas_n, we_n, ba, addr, dq} = pins;

   // Edges of the command clock
   reg ck_prev;
   wire ck_rise;
   wire ck_edge;
   assign ck_rise = ck_level & ~ck_prev;
   assign ck_edge = ck_level ^ ck_prev;

   // Command decode at the rising edge
   wire cmd_mrs;
   wire cmd_read;
   wire cmd_write;
   wire [1:0] bl_mode;
   wire cmd_chop;
   assign cmd_mrs = ck_rise & ~cs_n & ~ras_n & ~cas_n & ~we_n & (ba == 3'h0); // R20
   assign cmd_read = ck_rise & ~cs_n & ras_n & ~cas_n & we_n;
   assign cmd_write = ck_rise & ~cs_n & ras_n & ~cas_n & ~we_n;
   assign bl_mode = mode_reg_zero_o[`DMRZ_BL_HI:`DMRZ_BL_LO];
   // Chop when fixed, or on the fly with the select line low
   assign cmd_chop = (bl_mode == `DMRZ_BL_CHOP) |
                     ((bl_mode == `DMRZ_BL_OTF) & ~addr[`DMRZ_BC]); // R6

   // Beat store mirrors the array for read-back
   reg [15:0] store [0:7];

   // Read sequencer
   reg [1:0] rd_state;
   reg [5:0] rd_cnt;
   reg [2:0] rd_beat;
   reg [2:0] rd_start;
   reg rd_chop;
   reg rd_ilv;

   // Write sequencer
   reg [1:0] wr_state;
   reg [3:0] wr_cnt;
   reg [2:0] wr_beat;
   reg wr_bit2;
   reg wr_chop;
   reg wr_fixed;
   reg [4:0] rec_cnt;

   // Beat handoff into the FIFO
   reg push_valid;
   reg [18:0] push_data;
   wire fifo_in_ready;
   wire [18:0] fifo_out_data;
   wire fifo_out_valid;
   wire fifo_pop;
   assign fifo_pop = fifo_out_valid & (~beat_valid_o | beat_ready_i);

   dmrz_fifo #(
      .WIDTH(19),
      .DEPTH(16),
      .AW(4)
   ) u_fifo (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .in_data_i(push_data),
      .in_valid_i(push_valid),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_out_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_pop)
   );

   // Mode register write, DLL reset and decoded views
   always @(posedge clock_i)
   begin
      if (reset_i)
      begin
         ck_prev <= 1'b0;
         mode_reg_zero_o <= `DMRZ_RESET;
         column_latency_o <= `DMRZ_CL_BASE;
         total_read_latency_o <= 6'h00;
         burst_interleave_o <= 1'b0;
         test_mode_o <= 1'b0;
         dll_reset_o <= 1'b0;
         dll_restart_o <= 1'b0;
         write_recovery_o <= `DMRZ_WR_ZERO;
         autoprecharge_total_delay_o <= 6'h00;
         dll_frozen_o <= 1'b0;
         fast_exit_o <= 1'b0;
      end
      else
      begin
         ck_prev <= ck_level;
         dll_restart_o <= 1'b0;
         if (cmd_mrs)
         begin
            mode_reg_zero_o <= addr;
            dll_reset_o <= addr[`DMRZ_DLLR]; // R21
         end
         else if (dll_reset_o & ck_rise)
         begin
            dll_reset_o <= 1'b0; // R13
            dll_restart_o <= 1'b1; // R13
         end
         column_latency_o <= cl_decode(mode_reg_zero_o); // R1
         total_read_latency_o <= {2'h0, added_latency_i} +
                                 {1'b0, cl_decode(mode_reg_zero_o)}; // R3
         burst_interleave_o <= mode_reg_zero_o[`DMRZ_BT]; // R5
         test_mode_o <= mode_reg_zero_o[`DMRZ_TM]; // R4
         write_recovery_o <= wr_decode(mode_reg_zero_o[`DMRZ_WR_HI:`DMRZ_WR_LO]);
         autoprecharge_total_delay_o <= {1'b0, write_recovery_o} +
                                        {1'b0, precharge_period_i}; // R16
         fast_exit_o <= mode_reg_zero_o[`DMRZ_PPD]; // R19
         dll_frozen_o <= powerdown_i & ~mode_reg_zero_o[`DMRZ_PPD]; // R18
      end
   end

   // Read burst: wait total latency, then one beat per clock edge
   always @(posedge clock_i)
   begin
      if (reset_i)
      begin
         rd_state <= `DMRZ_S_IDLE;
         rd_cnt <= 6'h00;
         rd_beat <= 3'h0;
         rd_start <= 3'h0;
         rd_chop <= 1'b0;
         rd_ilv <= 1'b0;
         dq_o <= 16'h0000;
         dq_oe_o <= 1'b0;
         dqs_o <= 1'b0;
         dqs_oe_o <= 1'b0;
      end
      else
      begin
         case (rd_state)
            `DMRZ_S_IDLE:
            begin
               if (cmd_read)
               begin
                  rd_state <= `DMRZ_S_WAIT;
                  rd_cnt <= total_read_latency_o; // R3
                  rd_start <= addr[2:0];
                  rd_chop <= cmd_chop; // R6
                  rd_ilv <= mode_reg_zero_o[`DMRZ_BT]; // R5
               end
            end
            `DMRZ_S_WAIT:
            begin
               if (ck_rise)
               begin
                  rd_cnt <= rd_cnt - 6'h01;
                  if (rd_cnt == 6'h01)
                  begin
                     rd_state <= `DMRZ_S_BURST;
                     rd_beat <= 3'h1;
                     dq_o <= store[burst_col(rd_start, 3'h0, rd_ilv)]; // R7
                     dq_oe_o <= 1'b1;
                     dqs_o <= 1'b1;
                     dqs_oe_o <= 1'b1;
                  end
               end
            end
            `DMRZ_S_BURST:
            begin
               if (ck_edge)
               begin
                  rd_beat <= rd_beat + 3'h1;
                  dqs_o <= ck_level;
                  dq_o <= store[burst_col(rd_start, rd_beat, rd_ilv)]; // R7 R8
                  // Chopped bursts keep their last four slots at high impedance
                  dq_oe_o <= ~(rd_chop & rd_beat[2]); // R8
                  dqs_oe_o <= ~(rd_chop & rd_beat[2]); // R8
                  if (rd_beat == 3'h0)
                  begin
                     rd_state <= `DMRZ_S_IDLE;
                     dq_oe_o <= 1'b0;
                     dqs_oe_o <= 1'b0;
                     dqs_o <= 1'b0;
                  end
               end
            end
            default:
               rd_state <= `DMRZ_S_IDLE;
         endcase
      end
   end

   // Write burst: capture beats, queue kept ones, mark internal start
   always @(posedge clock_i)
   begin
      if (reset_i)
      begin
         wr_state <= `DMRZ_S_IDLE;
         wr_cnt <= 4'h0;
         wr_beat <= 3'h0;
         wr_bit2 <= 1'b0;
         wr_chop <= 1'b0;
         wr_fixed <= 1'b0;
         push_valid <= 1'b0;
         push_data <= 19'h00000;
         internal_write_start_o <= 1'b0;
         beat_dropped_o <= 1'b0;
         rec_cnt <= 5'h00;
         recovery_busy_o <= 1'b0;
      end
      else
      begin
         push_valid <= 1'b0;
         internal_write_start_o <= 1'b0;
         if (push_valid & ~fifo_in_ready)
            beat_dropped_o <= 1'b1;
         case (wr_state)
            `DMRZ_S_IDLE:
            begin
               if (cmd_write)
               begin
                  wr_state <= `DMRZ_S_WAIT;
                  wr_cnt <= write_latency_i;
                  wr_bit2 <= addr[2]; // R9 R10
                  wr_chop <= cmd_chop; // R6
                  wr_fixed <= (bl_mode == `DMRZ_BL_CHOP); // R11 R12
                  wr_beat <= 3'h0;
               end
            end
            `DMRZ_S_WAIT:
            begin
               if (ck_rise & (wr_cnt <= 4'h1))
               begin
                  wr_state <= `DMRZ_S_BURST;
                  wr_beat <= 3'h1;
                  push_valid <= 1'b1;
                  push_data <= {wr_chop & wr_bit2, 2'h0, dq}; // R9 R10
               end
               else if (ck_rise)
                  wr_cnt <= wr_cnt - 4'h1;
            end
            `DMRZ_S_BURST:
            begin
               if (ck_edge)
               begin
                  wr_beat <= wr_beat + 3'h1;
                  // Ascending order; chop keeps only the first four beats
                  if (~(wr_chop & wr_beat[2]))
                  begin
                     push_valid <= 1'b1; // R9 R10
                     push_data <= {(wr_chop & wr_bit2) | wr_beat[2], wr_beat[1:0], dq};
                  end
                  // Fixed chop starts two clocks early; on-the-fly does not
                  if ((wr_fixed & (wr_beat == `DMRZ_LAST_CHOP)) |
                      (~wr_fixed & (wr_beat == `DMRZ_LAST_BEAT))) // R11 R12
                  begin
                     internal_write_start_o <= 1'b1;
                     rec_cnt <= write_recovery_o;
                  end
                  if (wr_beat == `DMRZ_LAST_BEAT)
                     wr_state <= `DMRZ_S_IDLE;
               end
            end
            default:
               wr_state <= `DMRZ_S_IDLE;
         endcase
         // Recovery window counted in command clocks from the internal start
         if (internal_write_start_o)
            recovery_busy_o <= 1'b1; // R11
         else if (ck_rise & recovery_busy_o)
         begin
            rec_cnt <= rec_cnt - 5'h01;
            if (rec_cnt <= 5'h01)
               recovery_busy_o <= 1'b0;
         end
      end
   end

   // Output stage of the write beat path, also updates the read-back store
   always @(posedge clock_i)
   begin
      if (reset_i)
      begin
         beat_valid_o <= 1'b0;
         beat_data_o <= 16'h0000;
         beat_column_o <= 3'h0;
         write_path_ready_o <= 1'b0;
      end
      else
      begin
         write_path_ready_o <= fifo_in_ready;
         if (beat_valid_o & beat_ready_i)
            store[beat_column_o] <= beat_data_o;
         if (fifo_pop)
         begin
            beat_valid_o <= 1'b1;
            beat_data_o <= fifo_out_data[15:0];
            beat_column_o <= fifo_out_data[18:16];
         end
         else if (beat_ready_i)
            beat_valid_o <= 1'b0;
      end
   end
endmodule // dmrz_decode

// *** rtl/dmrz_fifo.v ***
// Write beat FIFO with valid and ready on both sides
`timescale 1ns/100ps
module dmrz_fifo #(
   parameter WIDTH = 19,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // Clock and reset
   input wire clock_i,
   input wire reset_i,
   // Fill side
   input wire [WIDTH-1:0] in_data_i,
   input wire in_valid_i,
   output wire in_ready_o,
   // Drain side
   output wire [WIDTH-1:0] out_data_o,
   output wire out_valid_o,
   input wire out_ready_i
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] rd_ptr;
   reg [AW-1:0] wr_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;
   // Honest full and empty from the fill count
   assign in_ready_o = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   // Storage and pointers
   always @(posedge clock_i)
   begin
      if (reset_i)
      begin
         rd_ptr <= {AW{1'b0}};
         wr_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            mem[wr_ptr] <= in_data_i;
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push & ~pop)
            count <= count + 1'b1;
         else if (pop & ~push)
            count <= count - 1'b1;
      end
   end
endmodule // dmrz_fifo

// *** rtl/dmrz_map.vh ***
// Constants for the mode register zero decode block
// Overview of operation
// R1: Column latency comes from mode bits A2 and A6..A4, counted in clock cycles.
// R2: Only whole-cycle column latencies exist; no half-clock setting.
// R3: Read data appears after added latency plus column latency.
// R4: Controller keeps A7 at 0; 1 is an unsupported test mode.
// R5: Bit A3 selects sequential (0) or interleaved (1) burst order.
// R6: A1..A0 pick fixed chop, fixed eight or on-the-fly via A12.
// R7: Eight-beat reads follow sequential nibble rotation or start XOR beat.
// R8: Chopped reads give four beats in one nibble, then four high-Z slots.
// R9: Eight-beat writes store beats 0..7 in order; start bits ignored.
// R10: Chopped writes use start bit 2 for nibble, ascending, last four ignored.
// R11: Fixed chop starts the internal write two clocks earlier.
// R12: On-the-fly chop starts the internal write at the eight-beat point.
// R13: DLL reset bit clears itself once the reset is carried out.
// R14: Controller waits the lock time after DLL reset before reads.
// R15: Controller should reset the DLL after enabling it.
// R16: Recovery field plus precharge period form the auto-precharge delay.
// R17: Controller programs recovery at least recovery time over clock period.
// R18: A12 at 0 freezes the DLL in precharge power-down; slow exit.
// R19: A12 at 1 keeps the DLL running in power-down; fast exit.
// R20: Mode set is chip select, row, column, write strobes and bank all low.
// R21: DLL reset is requested by A8 high during the mode zero write.
`ifndef DMRZ_MAP_VH
`define DMRZ_MAP_VH
// Mode register zero field positions
`define DMRZ_BL_LO 0
`define DMRZ_BL_HI 1
`define DMRZ_CL_LOW 2
`define DMRZ_BT 3
`define DMRZ_CL_LO 4
`define DMRZ_CL_HI 6
`define DMRZ_TM 7
`define DMRZ_DLLR 8
`define DMRZ_WR_LO 9
`define DMRZ_WR_HI 11
`define DMRZ_PPD 12
`define DMRZ_AP 10
`define DMRZ_BC 12
`define DMRZ_RESET 13'h0000
// Burst length encodings
`define DMRZ_BL_EIGHT 2'h0
`define DMRZ_BL_OTF 2'h1
`define DMRZ_BL_CHOP 2'h2
// Latency offsets
`define DMRZ_CL_BASE 5'h04
`define DMRZ_CL_HIGH 5'h0c
`define DMRZ_WR_ZERO 5'h10
// Beat indices
`define DMRZ_LAST_CHOP 3'h3
`define DMRZ_LAST_BEAT 3'h7
// Read and write sequencer states
`define DMRZ_S_IDLE 2'h0
`define DMRZ_S_WAIT 2'h1
`define DMRZ_S_BURST 2'h2
`endif

// *** rtl/dmrz_sync.v ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module dmrz_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input wire clock_i,
   input wire reset_i,
   // Pins and settled levels
   input wire [WIDTH-1:0] pin_i,
   output reg [WIDTH-1:0] level_o
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   // Each bit settles once stages two and three agree
   always @(posedge clock_i)
   begin
      if (reset_i)
      begin
         stage1 <= {WIDTH{1'b0}};
         stage2 <= {WIDTH{1'b0}};
         stage3 <= {WIDTH{1'b0}};
         level_o <= {WIDTH{1'b0}};
      end
      else
      begin
         stage1 <= pin_i;
         stage2 <= stage1;
         stage3 <= stage2;
         level_o <= (stage2 & ~(stage2 ^ stage3)) | (level_o & (stage2 ^ stage3));
      end
   end
endmodule // dmrz_sync

// *** test/dmrz_ctrl_model.sv ***
// Command-side controller model driving the link pins
`timescale 1ns/100ps
module dmrz_ctrl_model (
   // Clock
   input wire clock_i,
   // Link pins
   output logic ck_o,
   output logic [3:0] cmd_n_o,
   output logic [2:0] ba_o,
   output logic [12:0] addr_o,
   output logic [15:0] dq_o
);
   // Idle pins; link clock still between frames
   initial
   begin
      ck_o = 1'b0;
      cmd_n_o = 4'hf;
      ba_o = 3'h7;
      addr_o = 13'h1fff;
      dq_o = 16'hffff;
   end
   // Half link period; data changes mid-way
   task automatic half(input [15:0] v);
      repeat (4) @(posedge clock_i);
      #1;
      dq_o = v;
      repeat (4) @(posedge clock_i);
      #1;
      ck_o = ~ck_o;
   endtask
   // Frame: command rise, eight beat slots, idle edges
   task automatic op(input [3:0] c, input [2:0] b, input [12:0] a, input [127:0] d,
                     input wr, input [5:0] tail);
      cmd_n_o = c;
      ba_o = b;
      addr_o = a;
      half(~dq_o);
      half(~dq_o);
      cmd_n_o = 4'hf;
      ba_o = ~b;
      addr_o = ~a;
      for (int i = 0; i < 8; i++)
         half(wr ? d[16*i +: 16] : ~dq_o);
      repeat (tail) half(~dq_o);
   endtask
endmodule  // dmrz_ctrl_model

// *** test/dmrz_decode_asserts.sv ***
// Concurrent checks on the mode register zero decode block ports
`timescale 1ns/100ps
module dmrz_decode_check (
   // Clock and reset
   input wire clock_i,
   input wire reset_i,
   // Watched inputs
   input wire [3:0] added_latency_i,
   input wire [4:0] precharge_period_i,
   input wire powerdown_i,
   input wire beat_ready_i,
   // Watched outputs
   input wire [12:0] mode_reg_zero_o,
   input wire [4:0] column_latency_o,
   input wire [5:0] total_read_latency_o,
   input wire burst_interleave_o,
   input wire [4:0] write_recovery_o,
   input wire [5:0] autoprecharge_total_delay_o,
   input wire dll_reset_o,
   input wire dll_frozen_o,
   input wire dq_oe_o,
   input wire dqs_oe_o,
   input wire internal_write_start_o,
   input wire beat_valid_o,
   input wire [15:0] beat_data_o,
   input wire [2:0] beat_column_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   // Expected field decodes
   function automatic [4:0] cl_of(input [12:0] m);
      cl_of = (m[2] ? 5'h0c : 5'h04) + {2'h0, m[6:4]};
   endfunction
   function automatic [4:0] wr_of(input [2:0] k);
      wr_of = (k == 3'h0) ? 5'h10 : (k < 3'h5 ? {2'h0, k} + 5'h04 : {1'h0, k, 1'h0});
   endfunction
   // Inputs settled for three cycles
   sequence rl_calm_s;
      ($stable(added_latency_i) && $stable(column_latency_o))[*3];
   endsequence
   sequence dal_calm_s;
      ($stable(precharge_period_i) && $stable(write_recovery_o))[*3];
   endsequence
   sequence pd_calm_s;
      ($stable(powerdown_i) && $stable(mode_reg_zero_o[12]))[*3];
   endsequence
   col_lat_a: assert property (column_latency_o == cl_of($past(mode_reg_zero_o)))
      else $error("column latency wrong");
   rd_lat_a: assert property (
      rl_calm_s |-> total_read_latency_o == {2'h0, added_latency_i} + {1'h0, column_latency_o})
      else $error("read latency wrong");
   burst_type_a: assert property (burst_interleave_o == $past(mode_reg_zero_o[3]))
      else $error("burst type wrong");
   rec_decode_a: assert property (
      write_recovery_o == wr_of($past(mode_reg_zero_o[11:9])))
      else $error("recovery decode wrong");
   ap_delay_a: assert property (
      dal_calm_s |-> autoprecharge_total_delay_o == write_recovery_o + precharge_period_i)
      else $error("precharge delay wrong");
   dll_clear_a: assert property ($rose(dll_reset_o) |-> ##[1:60] !dll_reset_o)
      else $error("DLL reset stuck");
   pd_frozen_a: assert property (
      pd_calm_s |-> dll_frozen_o == (powerdown_i && !mode_reg_zero_o[12]))
      else $error("DLL freeze wrong");
   strobe_pair_a: assert property (dq_oe_o == dqs_oe_o)
      else $error("strobe enable mismatch");
   write_pulse_a: assert property (internal_write_start_o |=> !internal_write_start_o)
      else $error("write start too long");
   beat_hold_a: assert property (beat_valid_o && !beat_ready_i |=>
      beat_valid_o && $stable(beat_data_o) && $stable(beat_column_o))
      else $error("stalled beat changed");
endmodule  // dmrz_decode_check
bind dmrz_decode dmrz_decode_check u_check (.clock_i, .reset_i, .added_latency_i,
   .precharge_period_i, .powerdown_i, .beat_ready_i, .mode_reg_zero_o, .column_latency_o,
   .total_read_latency_o, .burst_interleave_o, .write_recovery_o,
   .autoprecharge_total_delay_o, .dll_reset_o, .dll_frozen_o, .dq_oe_o, .dqs_oe_o,
   .internal_write_start_o, .beat_valid_o, .beat_data_o, .beat_column_o);

// *** test/testbench.sv ***
// Self-checking bench for the mode register zero decode block
`timescale 1ns/100ps
module testbench;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic [3:0] added_latency_i = 4'h3;
   logic [4:0] precharge_period_i = 5'h06;
   logic powerdown_i = 1'b1;
   logic beat_ready_i = 1'b0;
   wire ck_i, dq_oe_o, dqs_o, dqs_oe_o, beat_valid_o, write_path_ready_o, beat_dropped_o;
   wire burst_interleave_o, test_mode_o, dll_reset_o, dll_restart_o;
   wire internal_write_start_o, dll_frozen_o, fast_exit_o;
   wire [3:0] cmd_n;
   wire [2:0] ba_i, beat_column_o;
   wire [12:0] addr_i, mode_reg_zero_o;
   wire [15:0] dq_i, dq_o, beat_data_o;
   wire [4:0] column_latency_o, write_recovery_o;
   wire [5:0] total_read_latency_o, autoprecharge_total_delay_o;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [12:0] rm [5] = '{13'h0000, 13'h0008, 13'h000a, 13'h0001, 13'h0009};
   logic [12:0] ra [5] = '{13'h0005, 13'h0005, 13'h0007, 13'h1003, 13'h0006};
   dmrz_ctrl_model u_ctrl (.clock_i, .ck_o(ck_i), .cmd_n_o(cmd_n), .ba_o(ba_i),
      .addr_o(addr_i), .dq_o(dq_i));
   dmrz_decode u_dut (.clock_i, .reset_i, .ck_i, .cs_n_i(cmd_n[3]), .ras_n_i(cmd_n[2]),
      .cas_n_i(cmd_n[1]), .we_n_i(cmd_n[0]), .ba_i, .addr_i, .dq_i, .dq_o, .dq_oe_o, .dqs_o,
      .dqs_oe_o, .added_latency_i, .write_latency_i(4'h1), .precharge_period_i, .powerdown_i,
      .beat_data_o, .beat_column_o, .beat_valid_o, .beat_ready_i, .write_path_ready_o,
      .beat_dropped_o, .mode_reg_zero_o, .column_latency_o, .total_read_latency_o,
      .burst_interleave_o, .test_mode_o, .dll_reset_o, .dll_restart_o, .write_recovery_o,
      .autoprecharge_total_delay_o, .internal_write_start_o, .recovery_busy_o(),
      .dll_frozen_o, .fast_exit_o);
   // Clock and hang guard
   always #5 clock_i = ~clock_i;
   always @(posedge clock_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         err_total++;
         end_of_test();
      end
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   // Beat i carries its column pattern
   function automatic [127:0] mkd(input [2:0] base);
      for (int i = 0; i < 8; i++)
         mkd[16*i +: 16] = 16'hc3c0 | 16'(3'(base + i));
   endfunction
   task automatic mset(input [12:0] a);
      u_ctrl.op(4'h0, 3'h0, a, 128'h0, 1'b0, 6'h04);
   endtask
   // Write burst; cycles to internal start
   task automatic wr(input [12:0] a, input [2:0] base, output int t);
      t = 0;
      fork
         u_ctrl.op(4'h4, 3'h0, a, mkd(base), 1'b1, 6'h04);
         while (t < 400 && internal_write_start_o !== 1'b1)
         begin
            tick(1);
            t++;
         end
      join
   endtask
   // Accept and compare queued beats
   task automatic drain(input int n, input [2:0] base, input int len);
      int k;
      k = 0;
      beat_ready_i = 1'b1;
      repeat (60)
      begin
         if (beat_valid_o === 1'b1)
         begin
            check("column", beat_column_o, 3'(base + k % len));
            check("beat", beat_data_o, 16'hc3c0 | 16'(3'(base + k % len)));
            k++;
         end
         tick(1);
      end
      beat_ready_i = 1'b0;
      check("count", 16'(k), 16'(n));
   endtask
   // Read burst order, strobe, released slots
   task automatic rd(input [12:0] a, input chop, input il);
      logic [2:0] c;
      int w;
      w = 0;
      fork
         u_ctrl.op(4'h5, 3'h0, a, 128'h0, 1'b0, 6'h14);
         begin
            while (w < 600 && dq_oe_o !== 1'b1)
            begin
               tick(1);
               w++;
            end
            for (int i = 0; i < 8; i++)
            begin
               tick(i == 0 ? 4 : 8);
               c = il ? a[2:0] ^ 3'(i) : {a[2] ^ (i > 3), a[1:0] + 2'(i)};
               if (chop && i > 3)
                  check("hiz", {dq_oe_o, dqs_oe_o}, 2'h0);
               else
               begin
                  check("rdata", dq_o, 16'hc3c0 | 16'(c));
                  check("strobe", {dq_oe_o, dqs_o}, {1'b1, ~i[0]});
               end
            end
         end
      join
   endtask
   task automatic decode_loop();
      logic [12:0] a;
      logic [4:0] r;
      for (int k = 0; k < 8; k++)
      begin
         a = {k[0], 3'(k), 1'b0, 1'b0, 3'(k), k[1], k[0], 2'h0};
         r = k == 0 ? 5'h10 : (k < 5 ? 5'(k + 4) : 5'(2 * k));
         mset(a);
         check("mode", mode_reg_zero_o, a);
         check("cl", column_latency_o, (k[0] ? 5'h0c : 5'h04) + 5'(k));
         check("rl", total_read_latency_o, 6'(3 + (k[0] ? 12 : 4) + k));
         check("bt", burst_interleave_o, k[1]);
         check("tm", test_mode_o, 1'b0);
         check("wr", write_recovery_o, r);
         check("dal", autoprecharge_total_delay_o, 6'(r + 6));
         check("pd", {dll_frozen_o, fast_exit_o}, {~k[0], k[0]});
      end
   endtask
   task automatic dll_reset();
      int seen;
      seen = 0;
      fork
         mset(13'h0100);
         repeat (110)
         begin
            tick(1);
            seen |= (dll_reset_o === 1'b1) ? 1 : 0;
            seen |= (dll_restart_o === 1'b1) ? 2 : 0;
         end
      join
      check("dll_seen", 16'(seen), 16'h0003);
      check("dll_clear", dll_reset_o, 1'b0);
   endtask
   task automatic fifo_full();
      int t;
      mset(13'h0000);
      repeat (3) wr(13'h0000, 3'h0, t);
      check("dropped", beat_dropped_o, 1'b1);
      check("room", write_path_ready_o, 1'b0);
      drain(17, 3'h0, 8);
      check("room", write_path_ready_o, 1'b1);
   endtask
   initial
   begin
      int t8, tc, to;
      tick(16);
      reset_i = 1'b0;
      tick(8);
      check("mode_rst", mode_reg_zero_o, 13'h0000);
      check("cl_rst", column_latency_o, 5'h04);
      check("wr_rst", write_recovery_o, 5'h10);
      decode_loop();
      dll_reset();
      added_latency_i = 4'h0;
      mset(13'h0000);
      wr(13'h0005, 3'h0, t8);
      drain(8, 3'h0, 8);
      mset(13'h0002);
      wr(13'h0006, 3'h4, tc);
      drain(4, 3'h4, 4);
      check("chop_start", 16'(t8 - tc), 16'h0020);
      mset(13'h0001);
      wr(13'h0004, 3'h4, to);
      drain(4, 3'h4, 4);
      check("otf_start", 16'(to), 16'(t8));
      for (int i = 0; i < 5; i++)
      begin
         mset(rm[i]);
         rd(ra[i], rm[i][1] || (rm[i][0] && !ra[i][12]), rm[i][3]);
      end
      fifo_full();
      end_of_test();
   end
endmodule  // testbench
